// [hw/dcf_pkg.sv]
// Shared constants for the two-port FIFO and mailbox port control
package dcf_pkg;
  localparam int unsigned DATA_W     = 36;    // Word width on both ports
  localparam int unsigned BYTE_W     = 9;     // Eight data bits plus parity in the top bit
  localparam int unsigned BYTES      = 4;     // Bytes per word
  localparam int unsigned DEPTH      = 64;    // FIFO words
  localparam int unsigned ADDR_W     = 6;     // Memory index width
  localparam int unsigned PTR_W      = 7;     // Pointer with wrap bit
  localparam int unsigned CTL_W      = 16;    // Synchronised control pins
  localparam int unsigned OFS_W      = 8;     // Flag offset width
  localparam logic [1:0]  FULL_EDGES = 2'h2;  // Port A edges after reset before full_flag rises
  // Offset presets picked by the two select pins
  localparam logic [7:0]  OFFSET_0   = 8'h10;
  localparam logic [7:0]  OFFSET_1   = 8'h0c;
  localparam logic [7:0]  OFFSET_2   = 8'h08;
  localparam logic [7:0]  OFFSET_3   = 8'h04;
  // Values while reset
  localparam logic        MAIL_FULL_RST = 1'b1;
  localparam logic [6:0]  PTR_RST       = 7'h00;
  localparam logic [15:0] CTL_RST       = 16'h0294;  // Both ports deselected and writing
endpackage : dcf_pkg

// [hw/dcf_port_ctrl.sv]
// Two-port FIFO of 36-bit words with mailboxes, parity check and parity generation
`timescale 1ns/1ps
module dcf_port_ctrl (
  // Core clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       reset,
  // Device pins: clocks, reset, strap and parity mode
  input  wire logic                       port_a_clock,
  input  wire logic                       port_b_clock,
  input  wire logic                       device_reset_n,
  input  wire logic                       offset_select_hi,
  input  wire logic                       offset_select_lo,
  input  wire logic                       parity_sense,
  // Port A control
  input  wire logic                       port_a_chip_select_n,
  input  wire logic                       port_a_qualify,
  input  wire logic                       port_a_direction,
  input  wire logic                       port_a_mailbox_sel,
  input  wire logic                       port_a_parity_gen,
  // Port A data pins
  input  wire logic [dcf_pkg::DATA_W-1:0] port_a_data_in,
  output logic      [dcf_pkg::DATA_W-1:0] port_a_data_out,
  output logic                            port_a_data_oe,
  // Port B control
  input  wire logic                       port_b_chip_select_n,
  input  wire logic                       port_b_qualify,
  input  wire logic                       port_b_direction,
  input  wire logic                       port_b_mailbox_sel,
  input  wire logic                       port_b_parity_gen,
  // Port B data pins
  input  wire logic [dcf_pkg::DATA_W-1:0] port_b_data_in,
  output logic      [dcf_pkg::DATA_W-1:0] port_b_data_out,
  output logic                            port_b_data_oe,
  // Flags, active low as on the pins, then the latched flag offset value
  output logic                            empty_flag,
  output logic                            full_flag,
  output logic                            a_to_b_mail_full,
  output logic                            b_to_a_mail_full,
  output logic                            port_a_parity_err,
  output logic                            port_b_parity_err,
  output logic      [dcf_pkg::OFS_W-1:0]  flag_offset_value
);

  // True when any byte of the word fails the selected parity
  function automatic logic parity_bad(input logic [dcf_pkg::DATA_W-1:0] w, input logic odd);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < dcf_pkg::BYTES; i++) begin
      bad = bad | ((^w[i*dcf_pkg::BYTE_W +: dcf_pkg::BYTE_W]) != odd);
    end
    return bad;
  endfunction

  // Replaces the top bit of each byte by generated parity
  function automatic logic [dcf_pkg::DATA_W-1:0] parity_fill(
    input logic [dcf_pkg::DATA_W-1:0] w, input logic odd);
    logic [dcf_pkg::DATA_W-1:0] r;
    r = w;
    for (int i = 0; i < dcf_pkg::BYTES; i++) begin
      r[i*dcf_pkg::BYTE_W+8] = (^w[i*dcf_pkg::BYTE_W +: 8]) ^ odd;
    end
    return r;
  endfunction

  logic [dcf_pkg::CTL_W-1:0]  ctl_s1;
  logic [dcf_pkg::CTL_W-1:0]  ctl_s2;
  logic [dcf_pkg::DATA_W-1:0] a_din_s1;
  logic [dcf_pkg::DATA_W-1:0] a_din;
  logic [dcf_pkg::DATA_W-1:0] b_din_s1;
  logic [dcf_pkg::DATA_W-1:0] b_din;
  logic                       a_clk_s;
  logic                       b_clk_s;
  logic                       rst_n_s;
  logic                       fs_hi;
  logic                       fs_lo;
  logic                       odd;
  logic                       a_cs_n;
  logic                       a_qual;
  logic                       a_dir;
  logic                       a_mb;
  logic                       a_pg;
  logic                       b_cs_n;
  logic                       b_qual;
  logic                       b_dir;
  logic                       b_mb;
  logic                       b_pg;
  logic                       a_clk_d;
  logic                       b_clk_d;
  logic                       rst_n_d;
  logic                       a_edge;
  logic                       b_edge;
  logic                       dev_rst;
  logic                       a_op;
  logic                       b_op;
  logic                       a_mb_wr;
  logic                       a_mb_rd;
  logic                       a_fifo_wr;
  logic                       b_mb_wr;
  logic                       b_mb_rd;
  logic                       b_fifo_rd;
  logic [dcf_pkg::DATA_W-1:0] mem [dcf_pkg::DEPTH];
  logic [dcf_pkg::DATA_W-1:0] fifo_out;
  logic [dcf_pkg::DATA_W-1:0] a_to_b_mailbox;
  logic [dcf_pkg::DATA_W-1:0] b_to_a_mailbox;
  logic [dcf_pkg::PTR_W-1:0]  wr_ptr;
  logic [dcf_pkg::PTR_W-1:0]  rd_ptr;
  logic [dcf_pkg::PTR_W-1:0]  wr_b1;
  logic [dcf_pkg::PTR_W-1:0]  wr_b2;
  logic [dcf_pkg::PTR_W-1:0]  rd_a1;
  logic [dcf_pkg::PTR_W-1:0]  rd_a2;
  logic [dcf_pkg::PTR_W-1:0]  fill_a;
  logic [1:0]                 full_wait;

  // Every pin crosses two flops; clocks and controls share the delay so they stay aligned
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctl_s1   <= dcf_pkg::CTL_RST;  // Idle pins, so no data pin is driven during reset
      ctl_s2   <= dcf_pkg::CTL_RST;
      a_din_s1 <= 36'h0_0000_0000;
      a_din    <= 36'h0_0000_0000;
      b_din_s1 <= 36'h0_0000_0000;
      b_din    <= 36'h0_0000_0000;
    end else begin
      ctl_s1   <= {port_a_clock, port_b_clock, device_reset_n, offset_select_hi,
                   offset_select_lo, parity_sense, port_a_chip_select_n, port_a_qualify,
                   port_a_direction, port_a_mailbox_sel, port_a_parity_gen,
                   port_b_chip_select_n, port_b_qualify, port_b_direction,
                   port_b_mailbox_sel, port_b_parity_gen};
      ctl_s2   <= ctl_s1;
      a_din_s1 <= port_a_data_in;
      a_din    <= a_din_s1;
      b_din_s1 <= port_b_data_in;
      b_din    <= b_din_s1;
    end
  end

  assign {a_clk_s, b_clk_s, rst_n_s, fs_hi, fs_lo, odd, a_cs_n, a_qual, a_dir, a_mb, a_pg,
          b_cs_n, b_qual, b_dir, b_mb, b_pg} = ctl_s2;

  // Edge finders on the sampled port clocks and device reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      a_clk_d <= 1'b0;
      b_clk_d <= 1'b0;
      rst_n_d <= 1'b0;
    end else begin
      a_clk_d <= a_clk_s;
      b_clk_d <= b_clk_s;
      rst_n_d <= rst_n_s;
    end
  end

  assign a_edge  = a_clk_s & ~a_clk_d;
  assign b_edge  = b_clk_s & ~b_clk_d;
  assign dev_rst = ~rst_n_s;

  // Qualified operations decoded per port
  assign a_op      = a_edge & ~a_cs_n & a_qual & ~dev_rst;
  assign b_op      = b_edge & ~b_cs_n & b_qual & ~dev_rst;
  assign a_mb_wr   = a_op & a_dir & a_mb;
  assign a_mb_rd   = a_op & ~a_dir & a_mb;
  assign a_fifo_wr = a_op & a_dir & ~a_mb & full_flag;
  assign b_mb_wr   = b_op & b_dir & b_mb;
  assign b_mb_rd   = b_op & ~b_dir & b_mb;
  assign b_fifo_rd = b_op & ~b_dir & ~b_mb & empty_flag;

  // Offset preset caught at the release of device reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flag_offset_value <= dcf_pkg::OFFSET_0;
    end else if (rst_n_s & ~rst_n_d) begin
      unique case ({fs_hi, fs_lo})
        2'b00: flag_offset_value <= dcf_pkg::OFFSET_0;
        2'b01: flag_offset_value <= dcf_pkg::OFFSET_1;
        2'b10: flag_offset_value <= dcf_pkg::OFFSET_2;
        2'b11: flag_offset_value <= dcf_pkg::OFFSET_3;
      endcase
    end
  end

  // Write side: memory, write pointer and read pointer carried across two port A edges
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_ptr    <= dcf_pkg::PTR_RST;
      rd_a1     <= dcf_pkg::PTR_RST;
      rd_a2     <= dcf_pkg::PTR_RST;
      full_wait <= 2'h0;
    end else if (dev_rst) begin
      wr_ptr    <= dcf_pkg::PTR_RST;
      rd_a1     <= dcf_pkg::PTR_RST;
      rd_a2     <= dcf_pkg::PTR_RST;
      full_wait <= 2'h0;
    end else if (a_edge) begin
      rd_a1 <= rd_ptr;
      rd_a2 <= rd_a1;
      if (full_wait != dcf_pkg::FULL_EDGES) begin
        full_wait <= full_wait + 2'h1;
      end
      if (a_fifo_wr) begin
        wr_ptr <= wr_ptr + 7'h01;
      end
    end
  end

  // Storage itself needs no reset; only written words are ever read
  always_ff @(posedge core_clk) begin
    if (a_fifo_wr) begin
      mem[wr_ptr[dcf_pkg::ADDR_W-1:0]] <= a_din;
    end
  end

  // Read side: output register and write pointer seen through two port B edges
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_ptr   <= dcf_pkg::PTR_RST;
      wr_b1    <= dcf_pkg::PTR_RST;
      wr_b2    <= dcf_pkg::PTR_RST;
      fifo_out <= 36'h0_0000_0000;
    end else if (dev_rst) begin
      rd_ptr <= dcf_pkg::PTR_RST;
      wr_b1  <= dcf_pkg::PTR_RST;
      wr_b2  <= dcf_pkg::PTR_RST;
    end else if (b_edge) begin
      wr_b1 <= wr_ptr;
      wr_b2 <= wr_b1;
      if (b_fifo_rd) begin
        fifo_out <= mem[rd_ptr[dcf_pkg::ADDR_W-1:0]];
        rd_ptr   <= rd_ptr + 7'h01;
      end
    end
  end

  // Flags from delayed pointers; a stale view only ever errs towards empty or full
  assign fill_a     = wr_ptr - rd_a2;
  assign empty_flag = (wr_b2 != rd_ptr);
  assign full_flag  = (fill_a != 7'h40) && (full_wait == dcf_pkg::FULL_EDGES);

  // A-to-B mailbox; a new write outranks a read landing in the same cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      a_to_b_mailbox   <= 36'h0_0000_0000;
      a_to_b_mail_full <= dcf_pkg::MAIL_FULL_RST;
    end else if (dev_rst) begin
      a_to_b_mail_full <= dcf_pkg::MAIL_FULL_RST;
    end else if (a_mb_wr && a_to_b_mail_full) begin
      a_to_b_mailbox   <= a_din;
      a_to_b_mail_full <= 1'b0;
    end else if (b_mb_rd) begin
      a_to_b_mail_full <= 1'b1;
    end
  end

  // B-to-A mailbox, same priority as above
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      b_to_a_mailbox   <= 36'h0_0000_0000;
      b_to_a_mail_full <= dcf_pkg::MAIL_FULL_RST;
    end else if (dev_rst) begin
      b_to_a_mail_full <= dcf_pkg::MAIL_FULL_RST;
    end else if (b_mb_wr && b_to_a_mail_full) begin
      b_to_a_mailbox   <= b_din;
      b_to_a_mail_full <= 1'b0;
    end else if (a_mb_rd) begin
      b_to_a_mail_full <= 1'b1;
    end
  end

  // Read data registers; generation reuses the check polarity
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port_a_data_out <= 36'h0_0000_0000;
      port_b_data_out <= 36'h0_0000_0000;
    end else begin
      port_a_data_out <= a_pg ? parity_fill(b_to_a_mailbox, odd) : b_to_a_mailbox;
      if (b_mb) begin
        port_b_data_out <= b_pg ? parity_fill(a_to_b_mailbox, odd) : a_to_b_mailbox;
      end else begin
        port_b_data_out <= b_pg ? parity_fill(fifo_out, odd) : fifo_out;
      end
    end
  end

  // Pins driven only while selected and reading
  assign port_a_data_oe = ~a_cs_n & ~a_dir;
  assign port_b_data_oe = ~b_cs_n & ~b_dir;

  // Parity error flags; the shared trees are busy while generating mailbox parity
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port_a_parity_err <= 1'b1;
      port_b_parity_err <= 1'b1;
    end else begin
      port_a_parity_err <= (~a_cs_n & a_qual & ~a_dir & a_mb & a_pg)
                           | ~parity_bad(a_din, odd);
      port_b_parity_err <= (~b_cs_n & b_qual & ~b_dir & b_mb & b_pg)
                           | ~parity_bad(b_din, odd);
    end
  end

  AST_OE_A_CS: assert property (@(posedge core_clk) disable iff (reset)
    $past(port_a_chip_select_n, 2) |-> !port_a_data_oe)
    else $error("port A drives while deselected");
  AST_OE_B_DIR: assert property (@(posedge core_clk) disable iff (reset)
    $past(port_b_direction, 2) |-> !port_b_data_oe)
    else $error("port B drives while writing");
  AST_EF_RESET: assert property (@(posedge core_clk) disable iff (reset)
    dev_rst |=> !empty_flag) else $error("empty flag high after device reset");
  AST_EF_ON_B: assert property (@(posedge core_clk) disable iff (reset)
    $changed(empty_flag) |-> $past(b_edge) || $past(dev_rst))
    else $error("empty flag moved without port B edge");
  AST_FF_RESET: assert property (@(posedge core_clk) disable iff (reset)
    dev_rst |=> !full_flag) else $error("full flag high after device reset");
  AST_NO_WR_FULL: assert property (@(posedge core_clk) disable iff (reset)
    !full_flag |=> wr_ptr == $past(wr_ptr)) else $error("write accepted while full");
  AST_MB1_WRITE: assert property (@(posedge core_clk) disable iff (reset)
    (a_mb_wr && a_to_b_mail_full) |=> !a_to_b_mail_full && a_to_b_mailbox == $past(a_din))
    else $error("mailbox write did not land");
  AST_MB1_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    (!a_to_b_mail_full && !b_mb_rd && !dev_rst) |=> $stable(a_to_b_mailbox))
    else $error("full mailbox overwritten");
  AST_MB2_READ: assert property (@(posedge core_clk) disable iff (reset)
    (a_mb_rd && !b_mb_wr) |=> b_to_a_mail_full) else $error("mailbox flag not raised");
  AST_PEA_FORCE: assert property (@(posedge core_clk) disable iff (reset)
    (~a_cs_n & a_qual & ~a_dir & a_mb & a_pg) |=> port_a_parity_err)
    else $error("parity error not forced during generation");
  AST_OFFSET: assert property (@(posedge core_clk) disable iff (reset)
    (rst_n_s && !rst_n_d && fs_hi && fs_lo) |=> flag_offset_value == dcf_pkg::OFFSET_3)
    else $error("offset preset not latched");

endmodule // dcf_port_ctrl

// [verif/dcf_port_master.sv]
// Bus master model for one port: free-running port clock, control pins and data pins
`timescale 1ns/1ps
module dcf_port_master #(
  parameter real PHASE = 0.0
) (
  // Port clock and control
  output logic             port_clock,
  output logic             chip_select_n,
  output logic             qualify,
  output logic             direction,
  output logic             mailbox_sel,
  output logic             parity_gen,
  // Data pins
  output logic [35:0]      data,
  input  wire logic [35:0] data_out
);
  // Continuous port clock, 200 ns period, phase unrelated to the core clock
  initial begin
    port_clock = 1'b0;
    #(PHASE);
    forever #100 port_clock = ~port_clock;
  end

  // Idle: deselected, unqualified, direction high so the device never drives
  initial begin
    {chip_select_n, qualify, direction, mailbox_sel, parity_gen} = 5'h14;
    data = 36'h0_0000_0000;
  end

  // Set up after a falling edge, act on the rising edge, read back one period later
  task automatic xfer(input logic [4:0] ctl, input logic [35:0] w, output logic [35:0] r);
    @(negedge port_clock);
    {chip_select_n, qualify, direction, mailbox_sel, parity_gen} = ctl;
    data = w;
    @(posedge port_clock);
    @(negedge port_clock);
    qualify = 1'b0;
    data = ~w; // Released lines show the inverse, never a stale copy
    @(posedge port_clock);
    r = data_out;
  endtask

  // Present a word with no transfer, for the passive parity check
  task automatic show(input logic [35:0] w);
    @(negedge port_clock);
    {chip_select_n, qualify, direction} = 3'h1;
    data = w;
    repeat (2) @(posedge port_clock);
  endtask
endmodule // dcf_port_master

// [verif/dual_clock_fifo_mailbox_ports_test.sv]
// Self-checking bench for the two-port FIFO and mailbox port control
`timescale 1ns/1ps
module dual_clock_fifo_mailbox_ports_test;
  localparam logic [4:0] WR_FIFO  = 5'h0c;
  localparam logic [4:0] RD_FIFO  = 5'h08;
  localparam logic [4:0] WR_UNQ   = 5'h04;
  localparam logic [4:0] WR_DESEL = 5'h1c;
  localparam logic [4:0] WR_MAIL  = 5'h0e;
  localparam logic [4:0] RD_MPG   = 5'h0b;
  localparam logic [4:0] RD_FPG   = 5'h09;
  localparam logic [4:0] RD_MAIL  = 5'h0a;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        device_reset_n = 1'b0;
  logic        offset_select_hi = 1'b0;
  logic        offset_select_lo = 1'b0;
  logic        parity_sense = 1'b0;
  logic        a_clk, a_cs_n, a_qual, a_dir, a_mb, a_pg, a_oe;
  logic        b_clk, b_cs_n, b_qual, b_dir, b_mb, b_pg, b_oe;
  logic        empty_flag, full_flag, a_to_b_mail_full, b_to_a_mail_full;
  logic        port_a_parity_err, port_b_parity_err;
  logic [35:0] a_din, a_dout, b_din, b_dout, r;
  logic [7:0]  flag_offset_value;
  int          n_fail = 0;
  int          tests_run = 0;

  // Core clock, 25 ns period
  always #12.5 core_clk = ~core_clk;

  // Device under test and one master model per port
  dcf_port_ctrl i_dut (
    .core_clk, .reset, .port_a_clock(a_clk), .port_b_clock(b_clk), .device_reset_n,
    .offset_select_hi, .offset_select_lo, .parity_sense,
    .port_a_chip_select_n(a_cs_n), .port_a_qualify(a_qual), .port_a_direction(a_dir),
    .port_a_mailbox_sel(a_mb), .port_a_parity_gen(a_pg), .port_a_data_in(a_din),
    .port_a_data_out(a_dout), .port_a_data_oe(a_oe),
    .port_b_chip_select_n(b_cs_n), .port_b_qualify(b_qual), .port_b_direction(b_dir),
    .port_b_mailbox_sel(b_mb), .port_b_parity_gen(b_pg), .port_b_data_in(b_din),
    .port_b_data_out(b_dout), .port_b_data_oe(b_oe),
    .empty_flag, .full_flag, .a_to_b_mail_full, .b_to_a_mail_full,
    .port_a_parity_err, .port_b_parity_err, .flag_offset_value
  );
  dcf_port_master #(.PHASE(37.0)) i_ma (
    .port_clock(a_clk), .chip_select_n(a_cs_n), .qualify(a_qual), .direction(a_dir),
    .mailbox_sel(a_mb), .parity_gen(a_pg), .data(a_din), .data_out(a_dout)
  );
  dcf_port_master #(.PHASE(91.0)) i_mb (
    .port_clock(b_clk), .chip_select_n(b_cs_n), .qualify(b_qual), .direction(b_dir),
    .mailbox_sel(b_mb), .parity_gen(b_pg), .data(b_din), .data_out(b_dout)
  );

  // Compare and count; four-state compare so an unknown never matches
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Set each byte's top bit so the byte has even (odd=0) or odd (odd=1) parity
  function automatic logic [35:0] par(input logic [35:0] w, input logic odd);
    for (int i = 0; i < 4; i++) w[9*i+8] = (^w[9*i +: 8]) ^ odd;
    return w;
  endfunction

  // Device reset for every strap setting; last pass leaves the first preset
  task automatic t_reset();
    logic [7:0] ofs [4];
    ofs = '{dcf_pkg::OFFSET_0, dcf_pkg::OFFSET_1, dcf_pkg::OFFSET_2, dcf_pkg::OFFSET_3};
    for (int s = 3; s >= 0; s--) begin
      @(negedge core_clk);
      {offset_select_hi, offset_select_lo} = 2'(s);
      device_reset_n = 1'b0;
      repeat (5) @(posedge b_clk);
      @(negedge core_clk);
      check(empty_flag, 1'b0);
      check(full_flag, 1'b0);
      check({a_to_b_mail_full, b_to_a_mail_full}, 2'h3);
      device_reset_n = 1'b1;
      @(posedge a_clk);
      repeat (6) @(negedge core_clk);
      check(full_flag, 1'b0);
      @(posedge a_clk);
      repeat (6) @(negedge core_clk);
      check(full_flag, 1'b1);
      check(empty_flag, 1'b0);
      check(flag_offset_value, ofs[s]);
    end
    $display("t_reset done");
  endtask

  // Ignored writes, fill to full, refused write, drain, refused read
  task automatic t_fifo();
    check({a_oe, b_oe}, 2'h0);
    i_ma.xfer(WR_UNQ, 36'h0_dead_beef, r);
    i_ma.xfer(WR_DESEL, 36'h0_bad0_cafe, r);
    for (int i = 0; i < 64; i++) i_ma.xfer(WR_FIFO, {28'h3c3_c3c3, 8'(i)}, r);
    check(a_oe, 1'b0);
    check(full_flag, 1'b0);
    check(empty_flag, 1'b1);
    i_ma.xfer(WR_FIFO, 36'hf_ffff_ffff, r);
    for (int i = 0; i < 64; i++) begin
      i_mb.xfer(RD_FIFO, 36'h0_0000_0000, r);
      check(r, {28'h3c3_c3c3, 8'(i)});
    end
    check(b_oe, 1'b1);
    check(empty_flag, 1'b0);
    i_mb.xfer(RD_FIFO, 36'h0_0000_0000, r);
    check(r, 36'h3_c3c3_c33f);
    i_mb.xfer(RD_FPG, 36'h0_0000_0000, r);
    check(r, par(36'h3_c3c3_c33f, 1'b0));
    $display("t_fifo done");
  endtask

  // Both mailboxes with their flags, generated parity and forced error flags
  task automatic t_mail();
    i_ma.xfer(WR_MAIL, 36'h1_2345_6789, r);
    check(a_to_b_mail_full, 1'b0);
    i_ma.xfer(WR_MAIL, 36'h0_0000_0000, r);
    @(negedge core_clk);
    parity_sense = 1'b1;
    fork
      i_mb.xfer(RD_MPG, 36'h0_0000_0000, r);
      begin
        @(negedge b_clk);
        @(posedge b_clk);
        @(negedge core_clk);
        check(port_b_parity_err, 1'b1);
      end
    join
    check(r, par(36'h1_2345_6789, 1'b1));
    check(a_to_b_mail_full, 1'b1);
    i_mb.xfer(WR_MAIL, 36'h8_0402_0100, r);
    check(b_to_a_mail_full, 1'b0);
    @(negedge core_clk);
    parity_sense = 1'b0;
    fork
      i_ma.xfer(RD_MPG, 36'h0_0000_0001, r);
      begin
        @(negedge a_clk);
        @(posedge a_clk);
        @(negedge core_clk);
        check(port_a_parity_err, 1'b1);
      end
    join
    check(r, 36'h0_0000_0000);
    check(b_to_a_mail_full, 1'b1);
    i_mb.xfer(WR_MAIL, 36'h7_89ab_cdef, r);
    i_ma.xfer(RD_MAIL, 36'h0_0000_0000, r);
    check(r, 36'h7_89ab_cdef);
    $display("t_mail done");
  endtask

  // One bad byte at each position, then a clean word, for both parity senses
  task automatic t_parity();
    logic [35:0] w;
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 5; k++) begin
        w = par(36'h5_1234_5678 + k, 1'(s));
        if (k < 4) w[9*k+8] = ~w[9*k+8];
        @(negedge core_clk);
        parity_sense = 1'(s);
        i_ma.show(w);
        i_mb.show(w);
        check(port_a_parity_err, k == 4);
        check(port_b_parity_err, k == 4);
      end
    end
    $display("t_parity done");
  endtask

  // Verdict, printed once
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    t_reset();
    t_fifo();
    t_mail();
    t_parity();
    tally_and_finish();
  end

  // Watchdog: the tests need about 70 us, so 200 us means a hang
  initial begin
    #200_000;
    n_fail++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    tally_and_finish();
  end
endmodule // dual_clock_fifo_mailbox_ports_test
